/* File: src/l2c_pkg.sv */
// Purpose: Shared constants and types for the L2 cache configuration block
// Assumes: 8-bit registers, one per aligned 32-bit word (index * 4)
// Notes:   Indices are register numbers; byte address is index shifted by 2
package l2c_pkg;
	// Register indices (byte address = index * 4)
	localparam logic [7:0] IDX_TYPE     = 8'h74;
	localparam logic [7:0] IDX_INIT     = 8'h75;
	localparam logic [7:0] IDX_TIMING   = 8'h76;
	localparam logic [7:0] IDX_SHAD_LO  = 8'h77;
	localparam logic [7:0] IDX_SHAD_HI  = 8'h78;
	localparam logic [7:0] IDX_R0_SIZE  = 8'h79;
	localparam logic [7:0] IDX_R0_BASE  = 8'h7a;
	localparam logic [7:0] IDX_R1_SIZE  = 8'h7b;
	localparam logic [7:0] IDX_R1_BASE  = 8'h7c;
	localparam logic [7:0] IDX_SEG89    = 8'h7d;
	localparam logic [7:0] IDX_STATUS   = 8'h7e;

	// Reset values
	localparam logic [7:0] RST_TYPE     = 8'h00;
	localparam logic [7:0] RST_INIT     = 8'h00;
	localparam logic [7:0] RST_TIMING   = 8'h0f;
	localparam logic [7:0] RST_ZERO     = 8'h00;

	// Writable bit masks; reserved bits read zero
	localparam logic [7:0] MASK_TYPE    = 8'h0f;
	localparam logic [7:0] MASK_TIMING  = 8'h3f;
	localparam logic [7:0] MASK_SEG89   = 8'h01;

	// Type register fields
	localparam int unsigned TYPE_PIPE   = 0;
	localparam int unsigned TYPE_BURST  = 1;
	localparam int unsigned TYPE_ASYNC  = 2;
	localparam int unsigned TYPE_XTAG   = 3;
	// Initialisation register fields
	localparam int unsigned INIT_IGNTAG = 7;
	localparam int unsigned INIT_FHIT   = 6;
	localparam int unsigned INIT_CLEAN  = 5;
	localparam int unsigned INIT_ADVCLK = 4;
	localparam int unsigned INIT_WBACK  = 3;
	localparam int unsigned INIT_SIZE   = 0;
	// Timing register fields
	localparam int unsigned TIM_RDFAST  = 5;
	localparam int unsigned TIM_WRFAST  = 4;
	localparam int unsigned TIM_RDLEAD  = 2;
	localparam int unsigned TIM_WRLEAD  = 0;

	// Cycle counts in clocks
	localparam logic [2:0] LEAD_SHORT   = 3'h3;
	localparam logic [2:0] LEAD_LONG    = 3'h4;
	localparam logic [2:0] BURST_FAST   = 3'h2;
	localparam logic [2:0] BURST_SLOW   = 3'h3;

	// Address map constants
	localparam int unsigned CACHE_MIN_SHIFT = 16;
	localparam int unsigned RANGE_SHIFT0    = 15;
	localparam logic [3:0]  RANGE_MAX_CODE  = 4'hc;
	localparam logic [2:0]  SIZE_MAX_CODE   = 3'h5;
	localparam logic [5:0]  SEG_C0000       = 6'h30;
	localparam logic [5:0]  SEG_E0000       = 6'h38;
	localparam logic [2:0]  SEG_89_TOP      = 3'h4;
	localparam logic [2:0]  SEG_AB_TOP      = 3'h5;

	// AXI responses
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// Selected SRAM protocol
	typedef enum logic [1:0] {
		L2C_OFF,
		L2C_ASYNC,
		L2C_BURST,
		L2C_PIPE
	} l2c_sram_e;

	// CPU lookup request
	typedef struct packed {
		logic [31:0] addr;
		logic        write;
	} l2c_req_s;

	// Tag SRAM read data for the indexed line
	typedef struct packed {
		logic [7:0] tag;
		logic       dirty;
	} l2c_tag_s;

	// Lookup answer
	typedef struct packed {
		logic cacheable;
		logic hit;
		logic allocate;
		logic range_hit;
		logic dirty_wr;
	} l2c_resp_s;

	// Settings handed to the SRAM sequencer
	typedef struct packed {
		l2c_sram_e  sram;
		logic [2:0] size;
		logic       write_back;
		logic       adv_clk;
		logic [2:0] rd_lead;
		logic [2:0] rd_burst;
		logic [2:0] wr_lead;
		logic [2:0] wr_burst;
	} l2c_timing_s;
endpackage

/* File: src/l2c_cache_cfg.sv */
// Purpose: L2 cache configuration registers and cacheability/hit decode
// Assumes: AXI4-Lite slave, aclk 200 MHz, synchronous active-low reset
// Notes:   Lookup answer appears one clock after the request
`timescale 1ns/1ps
`default_nettype none
module l2c_cache_cfg
	import l2c_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              req_valid,
	input  wire l2c_req_s          req,
	input  wire l2c_tag_s          tag_in,
	output logic                   resp_valid,
	output l2c_resp_s              resp,
	output l2c_timing_s            timing
);
	// Configuration registers
	logic [7:0]        type_reg;     // SRAM type and extra tag
	logic [7:0]        init_reg;     // Init modes, policy, size
	logic [7:0]        tim_reg;      // Async burst timing
	logic [7:0]        shad_lo;      // C0000-DFFFF cacheable
	logic [7:0]        shad_hi;      // E0000-FFFFF cacheable
	logic [7:0]        r0_size;      // Range 0 base A19-A16, size code
	logic [7:0]        r0_base;      // Range 0 base A27-A20
	logic [7:0]        r1_size;      // Range 1 base A19-A16, size code
	logic [7:0]        r1_base;      // Range 1 base A27-A20
	logic [7:0]        seg89;        // 80000/90000 cacheable
	logic [7:0]        status;       // Live state for software
	// Write channel holding state
	logic              aw_held;      // Write address captured
	logic              w_held;       // Write data captured
	logic [ADDR_W-1:0] aw_addr;      // Captured write address
	logic [31:0]       w_data;       // Captured write data
	logic              w_lane0;      // Low byte lane enabled
	logic              wr_fire;      // Both halves present
	// Lookup decode
	logic              l2_en;        // Any SRAM type selected
	logic              ign_tag;
	logic              force_hit;
	logic              force_clean;
	logic              seg_ok;       // Address-map cacheable
	logic              rng0;
	logic              rng1;
	logic              rng_any;
	logic              cacheable_now;
	logic [7:0]        addr_tag;
	logic              tag_match;
	logic              hit_now;
	l2c_sram_e         next_sram;

	// Register index from a byte address
	function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
		reg_idx = a[9:2];
	endfunction

	// Index is implemented and the upper address bits are clear
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		mapped = (i >= IDX_TYPE) && (i <= IDX_STATUS)
			&& (a[ADDR_W-1:10] == '0);
	endfunction

	// Non-cacheable window match on A27..An
	function automatic logic range_match(
		input logic [31:0] a,
		input logic [7:0]  sz,
		input logic [7:0]  hi
	);
		logic [27:0] base;
		logic [27:0] mask;
		logic [4:0]  n;
		base = {hi, sz[7:4], 16'h0000};
		n    = 5'(RANGE_SHIFT0) + {1'b0, sz[3:0]};
		mask = ~((28'h000_0001 << n) - 28'h000_0001);
		if (sz[3:0] == 4'h0 || sz[3:0] > RANGE_MAX_CODE) begin
			range_match = 1'b0;
		end else begin
			range_match = (((a[27:0] ^ base) & mask) == 28'h000_0000);
		end
	endfunction

	// Address write channel: take address until the write completes
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	// Capture write address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// Capture write data; only lane 0 carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held  <= 1'b1;
			w_data  <= s_axi_wdata;
			w_lane0 <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	// Write response; unmapped indices answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes; reserved bits held at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			type_reg <= RST_TYPE;
			init_reg <= RST_INIT;
			tim_reg  <= RST_TIMING;
			shad_lo  <= RST_ZERO;
			shad_hi  <= RST_ZERO;
			r0_size  <= RST_ZERO;
			r0_base  <= RST_ZERO;
			r1_size  <= RST_ZERO;
			r1_base  <= RST_ZERO;
			seg89    <= RST_ZERO;
		end else if (wr_fire && w_lane0 && mapped(aw_addr)) begin
			case (reg_idx(aw_addr))
				IDX_TYPE:    type_reg <= w_data[7:0] & MASK_TYPE;
				IDX_INIT:    init_reg <= w_data[7:0];
				IDX_TIMING:  tim_reg  <= w_data[7:0] & MASK_TIMING;
				IDX_SHAD_LO: shad_lo  <= w_data[7:0];
				IDX_SHAD_HI: shad_hi  <= w_data[7:0];
				IDX_R0_SIZE: r0_size  <= w_data[7:0];
				IDX_R0_BASE: r0_base  <= w_data[7:0];
				IDX_R1_SIZE: r1_size  <= w_data[7:0];
				IDX_R1_BASE: r1_base  <= w_data[7:0];
				IDX_SEG89:   seg89    <= w_data[7:0] & MASK_SEG89;
				// Status is read-only; write is acknowledged and dropped
				default:     ;
			endcase
		end
	end

	// Read channel: one read in flight, answered the next clock
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (reg_idx(s_axi_araddr))
				IDX_TYPE:    s_axi_rdata <= {24'h00_0000, type_reg};
				IDX_INIT:    s_axi_rdata <= {24'h00_0000, init_reg};
				IDX_TIMING:  s_axi_rdata <= {24'h00_0000, tim_reg};
				IDX_SHAD_LO: s_axi_rdata <= {24'h00_0000, shad_lo};
				IDX_SHAD_HI: s_axi_rdata <= {24'h00_0000, shad_hi};
				IDX_R0_SIZE: s_axi_rdata <= {24'h00_0000, r0_size};
				IDX_R0_BASE: s_axi_rdata <= {24'h00_0000, r0_base};
				IDX_R1_SIZE: s_axi_rdata <= {24'h00_0000, r1_size};
				IDX_R1_BASE: s_axi_rdata <= {24'h00_0000, r1_base};
				IDX_SEG89:   s_axi_rdata <= {24'h00_0000, seg89};
				IDX_STATUS:  s_axi_rdata <= {24'h00_0000, status};
				default:     s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Protocol select; on a bad multi-bit setting the highest bit wins
	always_comb begin
		if (type_reg[TYPE_ASYNC]) begin
			next_sram = L2C_ASYNC;
		end else if (type_reg[TYPE_BURST]) begin
			next_sram = L2C_BURST;
		end else if (type_reg[TYPE_PIPE]) begin
			next_sram = L2C_PIPE;
		end else begin
			next_sram = L2C_OFF;
		end
	end

	// Settings to the SRAM sequencer, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timing <= '0;
		end else begin
			timing.sram       <= next_sram;
			// Undefined size codes fall back to the largest size
			timing.size       <= (init_reg[INIT_SIZE+:3] > SIZE_MAX_CODE)
				? SIZE_MAX_CODE : init_reg[INIT_SIZE+:3];
			timing.write_back <= init_reg[INIT_WBACK];
			timing.adv_clk    <= init_reg[INIT_ADVCLK];
			timing.rd_burst   <= tim_reg[TIM_RDFAST]
				? BURST_FAST : BURST_SLOW;
			timing.wr_burst   <= tim_reg[TIM_WRFAST]
				? BURST_FAST : BURST_SLOW;
			// Reserved lead-off code 00 runs the safe long lead-off
			timing.rd_lead    <= (tim_reg[TIM_RDLEAD+:2] == 2'h1)
				? LEAD_SHORT : LEAD_LONG;
			timing.wr_lead    <= (tim_reg[TIM_WRLEAD+:2] == 2'h1)
				? LEAD_SHORT : LEAD_LONG;
		end
	end

	// Address-map cacheability below 1 MB
	always_comb begin
		seg_ok = 1'b1;
		if (req.addr[31:20] == 12'h000) begin
			if (req.addr[19:14] >= SEG_E0000) begin
				seg_ok = shad_hi[req.addr[16:14]];
			end else if (req.addr[19:14] >= SEG_C0000) begin
				seg_ok = shad_lo[req.addr[16:14]];
			end else if (req.addr[19:17] == SEG_AB_TOP) begin
				seg_ok = 1'b0; // Video hole never cached
			end else if (req.addr[19:17] == SEG_89_TOP) begin
				seg_ok = seg89[0];
			end else begin
				seg_ok = 1'b1;
			end
		end
	end

	// Two independent non-cacheable windows
	assign rng0    = range_match(req.addr, r0_size, r0_base);
	assign rng1    = range_match(req.addr, r1_size, r1_base);
	assign rng_any = rng0 || rng1;

	assign l2_en         = (next_sram != L2C_OFF);
	assign cacheable_now = l2_en && seg_ok && !rng_any;

	// Tag for the line; index width follows the cache size
	assign addr_tag  = 8'(req.addr >> (CACHE_MIN_SHIFT
		+ int'(timing.size)));
	assign tag_match = (addr_tag[6:0] == tag_in.tag[6:0])
		&& (!type_reg[TYPE_XTAG] || addr_tag[7] == tag_in.tag[7]);
	assign ign_tag     = init_reg[INIT_IGNTAG];
	assign force_hit   = init_reg[INIT_FHIT];
	assign force_clean = init_reg[INIT_CLEAN];
	// Tag ignored: the init bit decides hit or miss
	assign hit_now = ign_tag ? force_hit : tag_match;

	// Lookup answer, one clock after the request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resp_valid <= 1'b0;
			resp       <= '0;
		end else begin
			resp_valid     <= req_valid;
			resp.range_hit <= req_valid && rng_any;
			resp.cacheable <= req_valid && cacheable_now;
			resp.hit       <= req_valid && cacheable_now && hit_now;
			// Reads allocate on a miss; writes do not allocate
			resp.allocate  <= req_valid && cacheable_now && !hit_now
				&& !req.write;
			resp.dirty_wr  <= req_valid && cacheable_now && hit_now
				&& req.write && init_reg[INIT_WBACK]
				&& !force_clean;
		end
	end

	// Status: enable, protocol and last lookup outcome
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status <= RST_ZERO;
		end else begin
			status[0]   <= l2_en;
			status[2:1] <= next_sram;
			if (req_valid) begin
				status[3] <= cacheable_now;
				status[4] <= cacheable_now && hit_now;
				status[5] <= rng_any;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_off_no_lookup: assert property (req_valid && type_reg[2:0] == 3'h0
		|=> resp_valid && !resp.cacheable && !resp.allocate)
		else $error("lookup while cache disabled");
	a_async_mode_sel: assert property (type_reg[TYPE_ASYNC]
		|=> timing.sram == L2C_ASYNC)
		else $error("async SRAM not selected");
	a_extra_tag_miss: assert property (req_valid && cacheable_now
		&& !ign_tag && type_reg[TYPE_XTAG]
		&& addr_tag[7] != tag_in.tag[7] |=> !resp.hit)
		else $error("extra tag bit not compared");
	a_forced_hit_init: assert property (req_valid && cacheable_now
		&& ign_tag && force_hit |=> resp.hit)
		else $error("forced hit missing");
	a_forced_miss_init: assert property (req_valid && cacheable_now
		&& ign_tag && !force_hit && !req.write
		|=> !resp.hit && resp.allocate)
		else $error("forced miss missing");
	a_clean_no_dirty: assert property (req_valid && force_clean
		|=> !resp.dirty_wr)
		else $error("dirty written while forced clean");
	a_wthru_no_dirty: assert property (req_valid
		&& !init_reg[INIT_WBACK] |=> !resp.dirty_wr)
		else $error("dirty set in write-through");
	a_rd_burst_fast: assert property (tim_reg[TIM_RDFAST]
		&& $stable(tim_reg) |=> timing.rd_burst == 3'h2)
		else $error("read burst not x-2-2-2");
	a_rd_lead_short: assert property (tim_reg[3:2] == 2'h1
		|=> timing.rd_lead == 3'h3)
		else $error("read lead-off not 3");
	a_wr_lead_long: assert property (tim_reg[1:0] == 2'h3
		|=> timing.wr_lead == 3'h4)
		else $error("write lead-off not 4");
	a_range_bypass: assert property (req_valid && rng_any
		|=> resp.range_hit && !resp.cacheable && !resp.allocate)
		else $error("range not bypassed");
	a_shadow_low_off: assert property (req_valid
		&& req.addr[31:14] == 18'h0_0030 && !shad_lo[0]
		|=> !resp.cacheable)
		else $error("C0000 cached while disabled");

	c_read_hit: cover property (req_valid ##1 resp.hit);
	c_read_alloc: cover property (req_valid ##1 resp.allocate);
	c_range_skip: cover property (req_valid && rng1 ##1 resp.range_hit);
	c_write_resp: cover property (wr_fire ##1 s_axi_bvalid);
endmodule
`default_nettype wire

/* File: verification/l2c_tag_sram_model.sv */
// Purpose: Behavioural tag SRAM facing the lookup port
// Assumes: Tag and dirty are valid in the cycle that req_valid is high
// Notes:   Between lookups the lines toggle, so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module l2c_tag_sram_model
	import l2c_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       req_valid,
	input  wire logic [7:0] line_tag,
	input  wire logic       line_dirty,
	output l2c_tag_s        tag_in
);
	l2c_tag_s last = '0; // Last value shown on the lines

	// Keep what the lines showed
	always_ff @(posedge aclk) begin
		last <= tag_in;
	end

	// Outside a lookup the SRAM is not read: show a changing pattern
	assign tag_in = req_valid ? l2c_tag_s'({line_tag, line_dirty})
		: l2c_tag_s'(~last);
endmodule
`default_nettype wire

/* File: verification/test_l2_cache_config_and_cacheability.sv */
// Purpose: Self-checking bench for the L2 configuration and decode block
// Assumes: 200 MHz clock; bus master waits on handshakes, for at most 50 clocks each
// Notes:   Lookups mostly run with forced hit so only cacheability shows
`timescale 1ns/1ps
`default_nettype none
module test_l2_cache_config_and_cacheability;
	import l2c_pkg::*;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [11:0] awaddr = '0;
	logic [11:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic        awvalid = 0;
	logic        wvalid = 0;
	logic        bready = 0;
	logic        arvalid = 0;
	logic        rready = 0;
	logic        req_valid = 0;
	l2c_req_s    req = '0;
	logic [7:0]  line_tag = '0;
	logic        awready, wready, bvalid, arready, rvalid, resp_valid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	l2c_resp_s   resp;
	l2c_timing_s timing;
	l2c_tag_s    tag_in;
	int          fail_count = 0;
	int          tests_run = 0;

	// Clock inverts each half period
	always #2.5 aclk = ~aclk;

	l2c_cache_cfg #(.ADDR_W(12)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.req_valid(req_valid), .req(req), .tag_in(tag_in),
		.resp_valid(resp_valid), .resp(resp), .timing(timing));

	l2c_tag_sram_model tag_u (.aclk(aclk), .req_valid(req_valid),
		.line_tag(line_tag), .line_dirty(1'b0), .tag_in(tag_in));

	// Byte address of a register index
	function automatic logic [11:0] ra(input logic [7:0] idx);
		return 12'({idx, 2'b00});
	endfunction

	task automatic chk(input string nm, input logic [35:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Write: AW and W offered together, each dropped when taken
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] er);
		int         n;
		logic       ah, wh, b;
		logic [1:0] bs;
		n = 0;
		b = 0;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!b && n < 50) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			b = bvalid;
			bs = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 0;
			if (wh) wvalid <= 0;
			n++;
		end
		bready <= 0;
		chk("bresp", {b, bs}, {1'b1, er});
		// Let an edge pass so a following call never re-raises bready at once
		@(posedge aclk);
	endtask

	// Read: hold AR until taken, rready until rvalid seen
	task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed,
		input logic [1:0] er);
		int          n;
		logic        ah, r;
		logic [33:0] got;
		n = 0;
		r = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!r && n < 50) begin
			@(negedge aclk);
			ah = arvalid && arready;
			r = rvalid;
			got = {rresp, rdata};
			@(posedge aclk);
			if (ah) arvalid <= 0;
			n++;
		end
		rready <= 0;
		chk("rdata", {r, got}, {1'b1, er, 24'h00_0000, ed});
		// Let an edge pass so a following call never re-raises rready at once
		@(posedge aclk);
	endtask

	// One lookup; answer is expected one clock later
	task automatic look(input logic [31:0] a, input logic w,
		input logic [7:0] t, input logic [4:0] e);
		req_valid <= 1;
		req <= '{addr: a, write: w};
		line_tag <= t;
		@(posedge aclk);
		req_valid <= 0;
		@(negedge aclk);
		chk("resp", {resp_valid, resp}, {1'b1, e});
		@(posedge aclk);
	endtask

	// Let a register write reach the timing outputs
	task automatic settle;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic t_regs;
		timing_reset_check();
		for (int i = 0; i < 10; i++) begin
			axi_rd(ra(IDX_TYPE + 8'(i)), (i == 2) ? RST_TIMING : RST_ZERO,
				RESP_OKAY);
		end
		axi_wr(ra(IDX_TYPE), 8'hff, RESP_OKAY);
		axi_rd(ra(IDX_TYPE), MASK_TYPE, RESP_OKAY);
		axi_wr(ra(IDX_TIMING), 8'hff, RESP_OKAY);
		axi_rd(ra(IDX_TIMING), MASK_TIMING, RESP_OKAY);
		axi_wr(ra(IDX_SEG89), 8'hff, RESP_OKAY);
		axi_rd(ra(IDX_SEG89), MASK_SEG89, RESP_OKAY);
		// Unmapped place answers with an error, reads zero
		axi_wr(12'h100, 8'h5a, RESP_SLVERR);
		axi_rd(12'h100, 8'h00, RESP_SLVERR);
		axi_wr(ra(IDX_SEG89), 8'h00, RESP_OKAY);
		axi_wr(ra(IDX_TIMING), RST_TIMING, RESP_OKAY);
	endtask

	task automatic timing_reset_check;
		@(negedge aclk);
		chk("timing", 36'(timing), 36'({2'b00, 5'h00, LEAD_LONG,
			BURST_SLOW, LEAD_LONG, BURST_SLOW}));
		@(posedge aclk);
	endtask

	task automatic t_type;
		logic [7:0] tv[4] = '{8'h04, 8'h02, 8'h01, 8'h00};
		l2c_sram_e  te[4] = '{L2C_ASYNC, L2C_BURST, L2C_PIPE, L2C_OFF};
		// Ignore-tag and forced hit go in before the type register is swept
		axi_wr(ra(IDX_INIT), 8'hc0, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			axi_wr(ra(IDX_TYPE), tv[i], RESP_OKAY);
			settle();
			chk("sram", 36'(timing.sram), 36'(te[i]));
			@(posedge aclk);
		end
		look(32'h0010_0000, 0, 8'h10, 5'b00000);
	endtask

	task automatic t_timing;
		logic [7:0]  tv[4] = '{8'h35, 8'h0a, 8'h0f, 8'h25};
		logic [11:0] te[4] = '{
			{LEAD_SHORT, BURST_FAST, LEAD_SHORT, BURST_FAST},
			{LEAD_LONG, BURST_SLOW, LEAD_LONG, BURST_SLOW},
			{LEAD_LONG, BURST_SLOW, LEAD_LONG, BURST_SLOW},
			{LEAD_SHORT, BURST_FAST, LEAD_SHORT, BURST_SLOW}};
		axi_wr(ra(IDX_TYPE), 8'h04, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			axi_wr(ra(IDX_TIMING), tv[i], RESP_OKAY);
			settle();
			chk("lead", 36'({timing.rd_lead, timing.rd_burst, timing.wr_lead,
				timing.wr_burst}), 36'(te[i]));
			@(posedge aclk);
		end
		axi_wr(ra(IDX_INIT), 8'h1d, RESP_OKAY);
		settle();
		chk("init", 36'({timing.size, timing.write_back, timing.adv_clk}),
			36'({3'h5, 2'b11}));
		@(posedge aclk);
	endtask

	// Tag compare, forced hit and miss, dirty handling
	task automatic t_tag;
		axi_wr(ra(IDX_INIT), 8'h00, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h10, 5'b11000);
		look(32'h0010_0000, 0, 8'h11, 5'b10100);
		look(32'h0010_0000, 0, 8'h90, 5'b11000);
		axi_wr(ra(IDX_TYPE), 8'h0c, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h90, 5'b10100);
		look(32'h0010_0000, 1, 8'h10, 5'b11000);
		axi_wr(ra(IDX_INIT), 8'h01, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h08, 5'b11000);
		axi_wr(ra(IDX_INIT), 8'h80, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h10, 5'b10100);
		axi_wr(ra(IDX_INIT), 8'hc0, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h55, 5'b11000);
		axi_wr(ra(IDX_INIT), 8'h08, RESP_OKAY);
		look(32'h0010_0000, 1, 8'h10, 5'b11001);
		axi_wr(ra(IDX_INIT), 8'h28, RESP_OKAY);
		look(32'h0010_0000, 1, 8'h10, 5'b11000);
	endtask

	task automatic t_shadow;
		logic [31:0] sa[5] = '{32'h000c_0000, 32'h000d_c000, 32'h000e_0000,
			32'h000f_c000, 32'h0008_0000};
		logic [7:0]  sr[5] = '{IDX_SHAD_LO, IDX_SHAD_LO, IDX_SHAD_HI,
			IDX_SHAD_HI, IDX_SEG89};
		logic [7:0]  sb[5] = '{8'h01, 8'h80, 8'h01, 8'h80, 8'h01};
		axi_wr(ra(IDX_INIT), 8'hc0, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			axi_wr(ra(sr[i]), ~sb[i], RESP_OKAY);
			look(sa[i], 0, 8'h00, 5'b00000);
			axi_wr(ra(sr[i]), sb[i], RESP_OKAY);
			look(sa[i], 0, 8'h00, 5'b11000);
		end
	endtask

	// Both windows, their edges, unused codes, a window over C0000 with its shadow bit off
	task automatic t_range;
		axi_wr(ra(IDX_R0_SIZE), 8'hf5, RESP_OKAY);
		axi_wr(ra(IDX_R0_BASE), 8'h01, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h00, 5'b00010);
		look(32'h001f_fffc, 0, 8'h00, 5'b00010);
		look(32'h0020_0000, 0, 8'h00, 5'b11000);
		axi_wr(ra(IDX_R1_SIZE), 8'h15, RESP_OKAY);
		axi_wr(ra(IDX_R1_BASE), 8'h02, RESP_OKAY);
		look(32'h0021_0000, 0, 8'h00, 5'b00010);
		look(32'h0030_0000, 0, 8'h00, 5'b11000);
		axi_wr(ra(IDX_R1_SIZE), 8'h05, RESP_OKAY);
		axi_wr(ra(IDX_R1_BASE), 8'h00, RESP_OKAY);
		look(32'h000c_0000, 0, 8'h00, 5'b00010);
		axi_wr(ra(IDX_R0_SIZE), 8'hfd, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h00, 5'b11000);
		axi_wr(ra(IDX_R0_SIZE), 8'hf0, RESP_OKAY);
		look(32'h0010_0000, 0, 8'h00, 5'b11000);
		axi_wr(ra(IDX_R0_SIZE), 8'h0c, RESP_OKAY);
		axi_wr(ra(IDX_R0_BASE), 8'h80, RESP_OKAY);
		look(32'h0800_0000, 0, 8'h00, 5'b00010);
		look(32'h07ff_fffc, 0, 8'h00, 5'b11000);
		// Status: enabled, async protocol, last lookup cacheable and hit
		axi_rd(ra(IDX_STATUS), 8'h1b, RESP_OKAY);
	endtask

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end
		else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Main sequence after an eight-cycle reset
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs();
		t_type();
		t_timing();
		t_tag();
		t_shadow();
		t_range();
		give_verdict();
	end

	// Whole run is a few hundred cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
